/* src/fsw_pkg.sv */
// package for the flash self-write control block: offsets, fields, constants, types
package fsw_pkg;
  // ==========================================================================
  // register index on the cpu register port
  localparam logic [2:0]  REG_DATA_LO   = 3'h0;
  localparam logic [2:0]  REG_DATA_HI   = 3'h1;
  localparam logic [2:0]  REG_ADDR_LO   = 3'h2;
  localparam logic [2:0]  REG_ADDR_HI   = 3'h3;
  localparam logic [2:0]  REG_CONTROL   = 3'h4;
  localparam logic [2:0]  REG_UNLOCK    = 3'h5;
  // ==========================================================================
  // control register fields
  localparam int          CTL_FIXED1    = 7;
  localparam int          CTL_SPACE     = 6;
  localparam int          CTL_LD_ONLY   = 5;
  localparam int          CTL_FREE      = 4;
  localparam int          CTL_ERR       = 3;
  localparam int          CTL_PGM_EN    = 2;
  localparam int          CTL_WR        = 1;
  localparam int          CTL_RD        = 0;
  // ==========================================================================
  // values
  localparam logic [7:0]  UNLOCK_KEY1   = 8'h55;
  localparam logic [7:0]  UNLOCK_KEY2   = 8'hAA;
  localparam logic [13:0] LATCH_BLANK   = 14'h3FFF;
  localparam logic [13:0] DATA_RESET    = 14'h0000;
  localparam logic [14:0] ADDR_RESET    = 15'h0000;
  localparam logic [4:0]  LATCH_LAST    = 5'h1F;
  localparam logic [14:0] CFG_UID_LAST  = 15'h0003;
  localparam logic [14:0] CFG_DEVID     = 15'h0006;
  localparam logic [14:0] CFG_CONF_LAST = 15'h0008;
  localparam logic [9:0]  ROW_ZERO      = 10'h000;
  // ==========================================================================
  // types
  typedef struct packed {
    logic       wr;
    logic [2:0] addr;
    logic [7:0] data;
  } fsw_cpu_req_t;

  typedef struct packed {
    logic        read;
    logic        erase;
    logic        prog;
    logic        cfg;
    logic [14:0] addr;
    logic [13:0] data;
  } fsw_flash_cmd_t;

  typedef enum logic [2:0] {
    ST_IDLE, ST_READ, ST_READ_CAP, ST_LOAD, ST_PROG, ST_PROG_WAIT, ST_ERASE_WAIT
  } fsw_state_t;
endpackage

/* src/fsw_latches.sv */
// row write latch array, blank on reset and after every row write or erase
module fsw_latches (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        load,
  input  wire logic [4:0]  load_idx,
  input  wire logic [13:0] load_data,
  input  wire logic        blank,
  input  wire logic [4:0]  rd_idx,
  output logic      [13:0] rd_data
);
  import fsw_pkg::*;

  logic [13:0] lat_r   [32];
  logic [13:0] lat_nxt [32];

  // ==========================================================================
  // one latch per word of the row
  for (genvar i = 0; i < 32; i++) begin : g_lat
    always_comb begin
      lat_nxt[i] = lat_r[i];
      if (blank) begin
        lat_nxt[i] = LATCH_BLANK;
      end else if (load && (load_idx == 5'(i))) begin
        lat_nxt[i] = load_data;
      end
    end
    always_ff @(posedge clk) begin
      if (!rst_n) begin
        lat_r[i] <= LATCH_BLANK;
      end else begin
        lat_r[i] <= lat_nxt[i];
      end
    end
  end

  assign rd_data = lat_r[rd_idx];
endmodule // fsw_latches

/* src/fsw_ctrl.sv */
// flash self-write control: data, address, control and unlock registers plus sequencer
// ============================================================================
// Operation
// - the low data register holds word bits 7..0, loaded by a read and used as write data.
// - the high data register holds word bits 13..8 in bits 5..0, and bits 7..6 read zero.
// - the low address register gives address bits 7..0 for read, erase and latch load.
// - the high address register gives address bits 14..8 in bits 6..0, and bit 7 reads one.
// - the error flag sets on an improper or disabled start attempt; zero means normal finish.
// - the error flag sets as a write or erase is started and clears when it completes.
// - software only sets the write start bit, the device clears it when the operation ends.
// - the read start bit fetches the addressed word into the data registers, then self-clears.
// - with space select set, accesses go to the id and configuration region, only ids writable.
// - latch-only loads just one latch; otherwise the row is programmed and latches go blank.
// - latch-only is ignored while erase select is set.
module fsw_ctrl (
  input  wire logic                     clk,
  input  wire logic                     rst_n,
  input  wire fsw_pkg::fsw_cpu_req_t    cpu_req,
  output logic      [7:0]               cpu_rdata,
  output logic                          cpu_busy,
  output fsw_pkg::fsw_flash_cmd_t       flash_cmd,
  input  wire logic [13:0]              flash_rdata,
  input  wire logic                     flash_done
);
  import fsw_pkg::*;

  fsw_state_t     st_r,    st_nxt;
  logic [13:0]    data_r,  data_nxt;
  logic [14:0]    addr_r,  addr_nxt;
  logic           space_r,   space_nxt;
  logic           ld_only_r, ld_only_nxt;
  logic           free_r,    free_nxt;
  logic           err_r,     err_nxt;
  logic           pgm_en_r,  pgm_en_nxt;
  logic           wr_r,    wr_nxt;
  logic           rd_r,    rd_nxt;
  logic           key1_r,  key1_nxt;
  logic           unl_r,   unl_nxt;
  logic [4:0]     idx_r,   idx_nxt;
  logic [7:0]     rdat_r,  rdat_nxt;
  logic           busy_r,  busy_nxt;
  fsw_flash_cmd_t cmd_r,   cmd_nxt;
  logic           lat_load;
  logic           lat_blank;
  logic [13:0]    lat_rdata;
  logic [7:0]     w;
  logic           wr_allowed;
  logic           cfg_rd_ok;
  logic [4:0]     last_idx;
  logic           ctl_wr;

  fsw_latches u_latches (
    .clk       (clk),
    .rst_n     (rst_n),
    .load      (lat_load),
    .load_idx  (addr_r[4:0]),
    .load_data (data_r),
    .blank     (lat_blank),
    .rd_idx    (idx_r),
    .rd_data   (lat_rdata)
  );

  assign w      = cpu_req.data;
  assign ctl_wr = cpu_req.wr && (cpu_req.addr == REG_CONTROL) && (st_r == ST_IDLE);
  // only the user ids may change in the id region; the erase covers row zero only
  assign wr_allowed = !w[CTL_SPACE] ||
                      (w[CTL_FREE] ? (addr_r[14:5] == ROW_ZERO) : (addr_r <= CFG_UID_LAST));
  assign cfg_rd_ok  = (addr_r <= CFG_UID_LAST) ||
                      ((addr_r >= CFG_DEVID) && (addr_r <= CFG_CONF_LAST));
  assign last_idx   = space_r ? CFG_UID_LAST[4:0] : LATCH_LAST;

  // ==========================================================================
  // next state
  always_comb begin
    st_nxt    = st_r;
    data_nxt  = data_r;
    addr_nxt  = addr_r;
    space_nxt   = space_r;
    ld_only_nxt = ld_only_r;
    free_nxt    = free_r;
    err_nxt     = err_r;
    pgm_en_nxt  = pgm_en_r;
    wr_nxt    = wr_r;
    rd_nxt    = rd_r;
    key1_nxt  = key1_r;
    unl_nxt   = unl_r;
    idx_nxt   = idx_r;
    lat_load  = 1'b0;
    lat_blank = 1'b0;
    cmd_nxt      = '0;
    cmd_nxt.cfg  = space_r;
    cmd_nxt.addr = addr_r;
    // register writes are refused while a sequence runs, the cpu is stalled then
    if (cpu_req.wr && (st_r == ST_IDLE)) begin
      // any write other than the matching key breaks the unlock sequence
      key1_nxt = 1'b0;
      unl_nxt  = 1'b0;
      unique case (cpu_req.addr)
        REG_DATA_LO: data_nxt[7:0]  = w;
        REG_DATA_HI: data_nxt[13:8] = w[5:0];
        REG_ADDR_LO: addr_nxt[7:0]  = w;
        REG_ADDR_HI: addr_nxt[14:8] = w[6:0];
        REG_UNLOCK: begin
          if (w == UNLOCK_KEY1) begin
            key1_nxt = 1'b1;
          end else if ((w == UNLOCK_KEY2) && key1_r) begin
            unl_nxt = 1'b1;
          end
        end
        REG_CONTROL: begin
          space_nxt   = w[CTL_SPACE];
          ld_only_nxt = w[CTL_LD_ONLY];
          free_nxt    = w[CTL_FREE];
          err_nxt     = w[CTL_ERR];
          pgm_en_nxt  = w[CTL_PGM_EN];
          if (w[CTL_RD]) begin
            rd_nxt       = 1'b1;
            cmd_nxt.read = 1'b1;
            cmd_nxt.cfg  = w[CTL_SPACE];
            st_nxt       = ST_READ;
          end else if (w[CTL_WR]) begin
            if (!w[CTL_PGM_EN]) begin
              err_nxt = 1'b1;
            end else if (!unl_r || !wr_allowed) begin
              err_nxt = 1'b1;
            end else begin
              wr_nxt  = 1'b1;
              err_nxt = 1'b1;
              cmd_nxt.cfg = w[CTL_SPACE];
              if (w[CTL_FREE]) begin
                cmd_nxt.erase = 1'b1;
                cmd_nxt.addr  = {addr_r[14:5], 5'h00};
                st_nxt        = ST_ERASE_WAIT;
              end else begin
                lat_load = 1'b1;
                idx_nxt  = 5'h00;
                st_nxt   = w[CTL_LD_ONLY] ? ST_LOAD : ST_PROG;
              end
            end
          end
        end
        default: ;
      endcase
    end
    unique case (st_r)
      ST_IDLE: ;
      ST_READ: st_nxt = ST_READ_CAP;
      ST_READ_CAP: begin
        // unmapped words of the id region read back as zero
        data_nxt = (!space_r || cfg_rd_ok) ? flash_rdata : DATA_RESET;
        rd_nxt   = 1'b0;
        st_nxt   = ST_IDLE;
      end
      ST_LOAD: begin
        wr_nxt  = 1'b0;
        err_nxt = 1'b0;
        st_nxt  = ST_IDLE;
      end
      ST_PROG: begin
        cmd_nxt.prog = 1'b1;
        cmd_nxt.addr = {addr_r[14:5], idx_r};
        cmd_nxt.data = lat_rdata;
        st_nxt       = ST_PROG_WAIT;
      end
      ST_PROG_WAIT: begin
        if (flash_done) begin
          if (idx_r == last_idx) begin
            lat_blank = 1'b1;
            wr_nxt    = 1'b0;
            err_nxt   = 1'b0;
            st_nxt    = ST_IDLE;
          end else begin
            idx_nxt = idx_r + 5'h01;
            st_nxt  = ST_PROG;
          end
        end
      end
      ST_ERASE_WAIT: begin
        if (flash_done) begin
          lat_blank = 1'b1;
          free_nxt  = 1'b0;
          wr_nxt    = 1'b0;
          err_nxt   = 1'b0;
          st_nxt    = ST_IDLE;
        end
      end
      default: st_nxt = ST_IDLE;
    endcase
    unique case (cpu_req.addr)
      REG_DATA_LO: rdat_nxt = data_r[7:0];
      REG_DATA_HI: rdat_nxt = {2'b00, data_r[13:8]};
      REG_ADDR_LO: rdat_nxt = addr_r[7:0];
      REG_ADDR_HI: rdat_nxt = {1'b1, addr_r[14:8]};
      REG_CONTROL: rdat_nxt = {1'b1, space_r, ld_only_r, free_r, err_r, pgm_en_r, wr_r, rd_r};
      default:     rdat_nxt = 8'h00;
    endcase
    busy_nxt = (st_nxt != ST_IDLE);
  end

  // ==========================================================================
  // registers
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_r   <= ST_IDLE;
      data_r <= DATA_RESET;
      addr_r <= ADDR_RESET;
      space_r   <= 1'b0;
      ld_only_r <= 1'b0;
      free_r    <= 1'b0;
      err_r     <= 1'b0;
      pgm_en_r  <= 1'b0;
      wr_r   <= 1'b0;
      rd_r   <= 1'b0;
      key1_r <= 1'b0;
      unl_r  <= 1'b0;
      idx_r  <= 5'h00;
      rdat_r <= 8'h00;
      busy_r <= 1'b0;
      cmd_r  <= '0;
    end else begin
      st_r   <= st_nxt;
      data_r <= data_nxt;
      addr_r <= addr_nxt;
      space_r   <= space_nxt;
      ld_only_r <= ld_only_nxt;
      free_r    <= free_nxt;
      err_r     <= err_nxt;
      pgm_en_r  <= pgm_en_nxt;
      wr_r   <= wr_nxt;
      rd_r   <= rd_nxt;
      key1_r <= key1_nxt;
      unl_r  <= unl_nxt;
      idx_r  <= idx_nxt;
      rdat_r <= rdat_nxt;
      busy_r <= busy_nxt;
      cmd_r  <= cmd_nxt;
    end
  end

  assign cpu_rdata = rdat_r;
  assign cpu_busy  = busy_r;
  assign flash_cmd = cmd_r;

  // ==========================================================================
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence s_start_ok;
    ctl_wr && !w[CTL_RD] && w[CTL_WR] && w[CTL_PGM_EN] && unl_r && wr_allowed;
  endsequence

  sequence s_read_walk;
    (cmd_r.read && rd_r) ##1 rd_r ##1 !rd_r;
  endsequence

  // the readback flop still holds its reset value on the first edge out of reset
  a_data_hi_top: assert property (
    $past(rst_n) && ($past(cpu_req.addr) == REG_DATA_HI) |->
    cpu_rdata == {2'b00, $past(data_r[13:8])})
    else $error("data high readback wrong");
  a_addr_hi_top: assert property (
    $past(rst_n) && ($past(cpu_req.addr) == REG_ADDR_HI) |->
    cpu_rdata == {1'b1, $past(addr_r[14:8])})
    else $error("address high readback wrong");
  a_disabled_start: assert property (
    ctl_wr && !w[CTL_RD] && w[CTL_WR] && !w[CTL_PGM_EN]
    |=> (!cmd_r.prog && !cmd_r.erase && !wr_r) [*2])
    else $error("start ran with program enable clear");
  a_disabled_err: assert property (
    ctl_wr && !w[CTL_RD] && w[CTL_WR] && !w[CTL_PGM_EN] |=> err_r)
    else $error("error flag not set on disabled start");
  a_start_err: assert property (s_start_ok |=> err_r && wr_r)
    else $error("error flag or start bit not set on start");
  a_read_walk: assert property (
    ctl_wr && w[CTL_RD] |=> s_read_walk)
    else $error("read start bit did not fetch and clear in time");
  a_erase_done: assert property (
    st_r == ST_ERASE_WAIT && flash_done |=> !free_r && !wr_r && !err_r)
    else $error("erase completion did not clear bits");
  a_latch_only: assert property (
    s_start_ok and (!w[CTL_FREE] && w[CTL_LD_ONLY]) |=> !cmd_r.prog ##1 (!wr_r && !cmd_r.prog))
    else $error("latch only load started a row write");
  a_locked_start: assert property (
    ctl_wr && !w[CTL_RD] && w[CTL_WR] && !unl_r |=> !wr_r && !cmd_r.erase)
    else $error("start accepted without unlock");
  a_free_wins: assert property (
    s_start_ok and w[CTL_FREE] |=> cmd_r.erase && st_r == ST_ERASE_WAIT)
    else $error("erase select did not win over latch only");
endmodule // fsw_ctrl

/* tb/fsw_flash_model.sv */
// behavioural flash array that answers the sequencer's read, program and erase pulses
module fsw_flash_model (
  clk,
  cmd,
  lat,
  rdata,
  done
);
  timeunit 1ns;
  timeprecision 1ns;
  import fsw_pkg::*;
  input  wire logic                    clk;
  input  wire fsw_pkg::fsw_flash_cmd_t cmd;
  input  wire logic [3:0]              lat;
  output logic      [13:0]             rdata;
  output logic                         done;
  // ==========================================================================
  // array contents, an absent word reads blank
  logic [13:0] mem [logic [15:0]];
  logic [3:0]  cnt;
  initial begin
    rdata = 14'h0000;
    done  = 1'b0;
    cnt   = 4'h0;
  end
  always @(posedge clk) begin
    done <= 1'b0;
    // between reads the data lines flip so a stale value never looks valid
    if (cmd.read) begin
      rdata <= mem.exists({cmd.cfg, cmd.addr}) ? mem[{cmd.cfg, cmd.addr}] : LATCH_BLANK;
    end else begin
      rdata <= ~rdata;
    end
    if (cmd.prog) begin
      mem[{cmd.cfg, cmd.addr}] = cmd.data;
    end
    if (cmd.erase) begin
      for (int i = 0; i < 32; i++) begin
        mem.delete({cmd.cfg, cmd.addr[14:5], i[4:0]});
      end
    end
    // self-timed operation: lat cycles from pulse to done, lat set by the bench
    if (cmd.prog || cmd.erase) begin
      cnt <= lat;
    end else if (cnt != 4'h0) begin
      cnt  <= cnt - 4'h1;
      done <= (cnt == 4'h1);
    end
  end
endmodule // fsw_flash_model

/* tb/fsw_ctrl_tb_top.sv */
// self-checking bench for the flash self-write control block
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin num_errors++; \
  $display("CHECK FAILED at %0t: got %h expected %h", $time, (g), (e)); end end
module fsw_ctrl_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import fsw_pkg::*;
  logic           clk;
  logic           rst_n;
  fsw_cpu_req_t   req;
  logic [7:0]     cpu_rdata;
  logic           cpu_busy;
  fsw_flash_cmd_t cmd;
  logic [13:0]    frd;
  logic           fdone;
  logic [3:0]     lat;
  logic [7:0]     v;
  int             num_errors = 0;
  int             tests_run = 0;
  int             n_ops = 0;
  int             ops0;
  fsw_ctrl DUT (.clk(clk), .rst_n(rst_n), .cpu_req(req), .cpu_rdata(cpu_rdata),
    .cpu_busy(cpu_busy), .flash_cmd(cmd), .flash_rdata(frd), .flash_done(fdone));
  fsw_flash_model u_flash (.clk(clk), .cmd(cmd), .lat(lat), .rdata(frd), .done(fdone));
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  always @(posedge clk) begin
    if (rst_n && (cmd.prog === 1'b1 || cmd.erase === 1'b1)) begin
      n_ops++;
    end
  end
  // ==========================================================================
  // access tasks
  task automatic summarize;
    $display("checks %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    #10;
    req = '{wr: 1'b1, addr: a, data: d};
    @(posedge clk);
    #10;
    req.wr = 1'b0;
  endtask
  task automatic chk_reg(input logic [2:0] a, input logic [7:0] e);
    @(posedge clk);
    #10;
    req.addr = a;
    repeat (2) @(posedge clk);
    #10;
    `CHK(cpu_rdata, e);
  endtask
  task automatic wait_idle;
    int n;
    @(posedge clk);
    #10;
    for (n = 0; n < 2000 && cpu_busy !== 1'b0; n++) begin
      @(posedge clk);
      #10;
    end
    if (n == 2000) begin
      num_errors++;
      summarize();
    end
  endtask
  // unlock values back to back, then the control byte
  task automatic start(input logic [7:0] c);
    wr_reg(REG_UNLOCK, UNLOCK_KEY1);
    wr_reg(REG_UNLOCK, UNLOCK_KEY2);
    wr_reg(REG_CONTROL, c);
  endtask
  task automatic set_word(input logic [14:0] a, input logic [13:0] d);
    wr_reg(REG_ADDR_LO, a[7:0]);
    wr_reg(REG_ADDR_HI, {1'b0, a[14:8]});
    wr_reg(REG_DATA_LO, d[7:0]);
    wr_reg(REG_DATA_HI, {2'b00, d[13:8]});
  endtask
  // data registers are preloaded with the inverse so a missed fetch shows
  task automatic chk_word(input logic c, input logic [14:0] a, input logic [13:0] e);
    set_word(a, ~e);
    wr_reg(REG_CONTROL, {1'b0, c, 6'h01});
    wait_idle();
    chk_reg(REG_DATA_LO, e[7:0]);
    chk_reg(REG_DATA_HI, {2'b00, e[13:8]});
  endtask
  // ==========================================================================
  // main sequence
  initial begin
    req   = '0;
    rst_n = 1'b0;
    lat   = 4'h1;
    repeat (5) @(posedge clk);
    #10;
    rst_n = 1'b1;
    chk_reg(REG_ADDR_LO, 8'h00);
    chk_reg(REG_ADDR_HI, 8'h80);
    chk_reg(REG_DATA_HI, 8'h00);
    chk_reg(REG_CONTROL, 8'h80);
    wr_reg(3'h7, 8'hFF);
    chk_reg(3'h7, 8'h00);
    chk_reg(REG_DATA_LO, 8'h00);
    $display("test reset done");
    wr_reg(REG_ADDR_HI, 8'hFF);
    chk_reg(REG_ADDR_HI, 8'hFF);
    wr_reg(REG_ADDR_LO, 8'hA5);
    chk_reg(REG_ADDR_LO, 8'hA5);
    wr_reg(REG_DATA_HI, 8'hFF);
    chk_reg(REG_DATA_HI, 8'h3F);
    wr_reg(REG_DATA_LO, 8'h5A);
    chk_reg(REG_DATA_LO, 8'h5A);
    $display("test fields done");
    ops0 = n_ops;
    start(8'h02);
    chk_reg(REG_CONTROL, 8'h88);
    wr_reg(REG_CONTROL, 8'h00);
    chk_reg(REG_CONTROL, 8'h80);
    wr_reg(REG_UNLOCK, UNLOCK_KEY1);
    wr_reg(REG_ADDR_LO, 8'h00);
    wr_reg(REG_UNLOCK, UNLOCK_KEY2);
    wr_reg(REG_CONTROL, 8'h06);
    chk_reg(REG_CONTROL, 8'h8C);
    `CHK(n_ops, ops0);
    $display("test refused done");
    lat = 4'h5;
    set_word(15'h0040, 14'h1234);
    start(8'h26);
    wait_idle();
    chk_reg(REG_CONTROL, 8'hA4);
    ops0 = n_ops;
    set_word(15'h0041, 14'h0ABC);
    start(8'h06);
    chk_reg(REG_CONTROL, 8'h8E);
    wait_idle();
    chk_reg(REG_CONTROL, 8'h84);
    `CHK(n_ops - ops0, 32);
    chk_word(1'b0, 15'h0040, 14'h1234);
    chk_word(1'b0, 15'h0041, 14'h0ABC);
    chk_word(1'b0, 15'h0042, 14'h3FFF);
    $display("test program done");
    lat = 4'h2;
    set_word(15'h0045, 14'h0000);
    start(8'h36);
    wait_idle();
    chk_reg(REG_CONTROL, 8'hA4);
    chk_word(1'b0, 15'h0040, 14'h3FFF);
    $display("test erase done");
    chk_word(1'b1, 15'h0009, 14'h0000);
    set_word(15'h0001, 14'h0155);
    start(8'h46);
    wait_idle();
    chk_word(1'b1, 15'h0001, 14'h0155);
    ops0 = n_ops;
    set_word(15'h0006, 14'h0000);
    start(8'h46);
    chk_reg(REG_CONTROL, 8'hCC);
    `CHK(n_ops, ops0);
    // latch 1 held a word before the last row write, so it must read blank now
    set_word(15'h0002, 14'h0077);
    start(8'h46);
    wait_idle();
    chk_word(1'b1, 15'h0001, 14'h3FFF);
    chk_word(1'b1, 15'h0002, 14'h0077);
    $display("test config done");
    summarize();
  end
endmodule // fsw_ctrl_tb_top
